/* rtc_value_pkg.sv */
// Contract
// (R1) weekday field bits 10-8, range 0..6
// (R2) hour tens bits 5-4, range 0..2
// (R3) hour ones bits 3-0, range 0..9
// (R4) weekday/hours, alarm month/day writes need unlock
// (R5) unimplemented bits always read zero
// (R6) minute tens bits 14-12, range 0..5
// (R7) minute ones bits 11-8, range 0..9
// (R8) second tens bits 6-4, bit 7 zero
// (R9) second ones bits 3-0, range 0..9
// (R10) alarm month tens bit 12, 15-13 zero
// (R11) alarm month ones bits 11-8, 0..9
// (R12) alarm day tens bits 5-4, 0..3
// (R13) alarm day ones bits 3-0, 0..9
// (R14) value fields have no reset value
package rtc_value_pkg;
	// register byte addresses on the apb word map
	localparam logic [7:0] ADDR_WEEKDAY_HOURS = 8'h00;
	localparam logic [7:0] ADDR_MINUTES_SECONDS = 8'h04;
	localparam logic [7:0] ADDR_ALARM_MONTH_DAY = 8'h08;
	localparam logic [7:0] ADDR_UNLOCK_CTRL = 8'h0c;
	// implemented-bit masks; everything else reads zero
	localparam logic [15:0] MASK_WEEKDAY_HOURS = 16'h073f;
	localparam logic [15:0] MASK_MINUTES_SECONDS = 16'h7f7f;
	localparam logic [15:0] MASK_ALARM_MONTH_DAY = 16'h1f3f;
	// unlock control bit position and reset value
	localparam int UNLOCK_BIT = 0;
	localparam logic UNLOCK_RESET = 1'b0;
endpackage

/* rtc_value_field.sv */
// one masked value register; fields are left unreset on purpose
module rtc_value_field #(
	parameter logic [15:0] MASK = 16'hffff
) (
	// clock
	input wire logic sys_clk,
	input wire logic clkEn,
	// write port
	input wire logic wrEn,
	input wire logic [15:0] wrData,
	// stored value, unimplemented bits forced low
	output logic [15:0] value
);
	logic [15:0] store_q; // contents undefined until first write

	// no reset: power-on contents stay unknown until software writes
	always_ff @(posedge sys_clk) begin // [R14]
		if (clkEn && wrEn) begin
			store_q <= wrData & MASK;
		end
	end

	assign value = store_q & MASK; // [R5]
endmodule // rtc_value_field

/* rtc_time_alarm_value_regs.sv */
// value registers for weekday/hours, minutes/seconds and alarm month/day
module rtc_time_alarm_value_regs (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	logic unlock_q; // clock_write_unlock
	logic [31:0] rdata_q; // registered read data
	logic access; // access phase of a transfer
	logic wrWkHr, wrMinSec, wrAlMd;
	logic [15:0] weekdayHours, minutesSeconds, alarmMonthDay;

	// decode of an address into register hit, used by the error response and the checks
	function automatic logic isMapped(input logic [7:0] a);
		return a == rtc_value_pkg::ADDR_WEEKDAY_HOURS ||
			a == rtc_value_pkg::ADDR_MINUTES_SECONDS ||
			a == rtc_value_pkg::ADDR_ALARM_MONTH_DAY ||
			a == rtc_value_pkg::ADDR_UNLOCK_CTRL;
	endfunction

	// zero wait states: every transfer completes in its first access cycle
	// a write lands on the rising edge that closes the access cycle, the same
	// edge at which the master samples pready high
	// clkEn low in that cycle drops the write: the enable freezes all state,
	// and the bus side is expected to keep the enable high while it talks
	assign access = psel && penable && clkEn;
	// no stretching is ever needed, so pready is a constant; a master that
	// waits for it still works, it simply never sees a wait state
	assign pready = 1'b1;
	// unmapped addresses answer with an error and no effect
	// kept combinational so that it stands exactly in the access cycle
	assign pslverr = psel && penable && !isMapped(paddr);

	// guarded writes: locked registers silently ignore writes
	assign wrWkHr = access && pwrite && paddr == rtc_value_pkg::ADDR_WEEKDAY_HOURS
		&& unlock_q; // [R4]
	assign wrAlMd = access && pwrite && paddr == rtc_value_pkg::ADDR_ALARM_MONTH_DAY
		&& unlock_q; // [R4]
	// minutes/seconds is not write-protected
	assign wrMinSec = access && pwrite && paddr == rtc_value_pkg::ADDR_MINUTES_SECONDS;

	// unlock bit: with rdata_q, the only state with a reset value
	// resetting it closed means a power-on glitch cannot open the protected
	// registers; software has to set it on purpose before a guarded write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			unlock_q <= rtc_value_pkg::UNLOCK_RESET;
		end else if (access && pwrite && paddr == rtc_value_pkg::ADDR_UNLOCK_CTRL) begin
			unlock_q <= pwdata[rtc_value_pkg::UNLOCK_BIT];
		end
	end

	// weekday and hour digits
	rtc_value_field #(.MASK(rtc_value_pkg::MASK_WEEKDAY_HOURS)) weekdayHoursReg ( // [R1] [R2] [R3]
		.sys_clk(sys_clk),
		.clkEn(clkEn),
		.wrEn(wrWkHr),
		.wrData(pwdata[15:0]),
		.value(weekdayHours)
	);

	// minute and second digits
	rtc_value_field #(.MASK(rtc_value_pkg::MASK_MINUTES_SECONDS)) minSecReg ( // [R6] [R7] [R8] [R9]
		.sys_clk(sys_clk),
		.clkEn(clkEn),
		.wrEn(wrMinSec),
		.wrData(pwdata[15:0]),
		.value(minutesSeconds)
	);

	// alarm month and day digits
	rtc_value_field #(.MASK(rtc_value_pkg::MASK_ALARM_MONTH_DAY)) alarmMdReg ( // [R10] [R11] [R12] [R13]
		.sys_clk(sys_clk),
		.clkEn(clkEn),
		.wrEn(wrAlMd),
		.wrData(pwdata[15:0]),
		.value(alarmMonthDay)
	);

	// read data registered in the setup cycle so it is valid in the access cycle
	// trade-off: a flop here keeps prdata glitch-free at the cost of needing
	// clkEn high in the setup cycle; the value then stands until the next setup
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (clkEn && psel && !penable) begin
			unique case (paddr)
				rtc_value_pkg::ADDR_WEEKDAY_HOURS: rdata_q <= {16'h0000, weekdayHours}; // [R5]
				rtc_value_pkg::ADDR_MINUTES_SECONDS: rdata_q <= {16'h0000, minutesSeconds};
				rtc_value_pkg::ADDR_ALARM_MONTH_DAY: rdata_q <= {16'h0000, alarmMonthDay};
				rtc_value_pkg::ADDR_UNLOCK_CTRL: rdata_q <= {31'h0000_0000, unlock_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign prdata = rdata_q;

	// checks below watch only what this block drives; all are disabled in reset
	// the zero, hold and freeze checks also sample the value fields before any write, while they are unknown

	// write to locked weekday/hours leaves contents unchanged
	AST_LOCKED_WKHR: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		access && pwrite && paddr == rtc_value_pkg::ADDR_WEEKDAY_HOURS && !unlock_q
		|=> $stable(weekdayHours))
		else $error("locked weekday write took effect");

	// write to locked alarm month/day leaves contents unchanged
	AST_LOCKED_ALMD: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		access && pwrite && paddr == rtc_value_pkg::ADDR_ALARM_MONTH_DAY && !unlock_q
		|=> $stable(alarmMonthDay))
		else $error("locked alarm write took effect");

	// unimplemented weekday/hours bits never show up in the stored value
	AST_WKHR_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
		(weekdayHours & ~rtc_value_pkg::MASK_WEEKDAY_HOURS) == 16'h0000)
		else $error("weekday reserved bits set");

	// unimplemented minutes/seconds bits never show up in the stored value
	AST_MINUTES_SECONDS_VALUE_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // [R5] [R8]
		(minutesSeconds & ~rtc_value_pkg::MASK_MINUTES_SECONDS) == 16'h0000)
		else $error("minutes reserved bits set");

	// unimplemented alarm month/day bits never show up in the stored value
	AST_ALMD_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // [R5] [R10]
		(alarmMonthDay & ~rtc_value_pkg::MASK_ALARM_MONTH_DAY) == 16'h0000)
		else $error("alarm reserved bits set");

	// minutes/seconds takes every written digit field, unguarded
	AST_MINUTES_SECONDS_VALUE_WRITE: assert property (@(posedge sys_clk) disable iff (rst) // [R6] [R7] [R8] [R9]
		access && pwrite && paddr == rtc_value_pkg::ADDR_MINUTES_SECONDS
		|=> minutesSeconds == ($past(pwdata[15:0]) & rtc_value_pkg::MASK_MINUTES_SECONDS))
		else $error("minutes write wrong");

	// unlocked weekday/hours write stores weekday and hour digits
	AST_WKHR_WRITE: assert property (@(posedge sys_clk) disable iff (rst) // [R1] [R2] [R3]
		access && pwrite && paddr == rtc_value_pkg::ADDR_WEEKDAY_HOURS && unlock_q
		|=> weekdayHours == ($past(pwdata[15:0]) & rtc_value_pkg::MASK_WEEKDAY_HOURS))
		else $error("weekday write wrong");

	// unlocked alarm month/day write stores month and day digits
	AST_ALMD_WRITE: assert property (@(posedge sys_clk) disable iff (rst) // [R10] [R11] [R12] [R13]
		access && pwrite && paddr == rtc_value_pkg::ADDR_ALARM_MONTH_DAY && unlock_q
		|=> alarmMonthDay == ($past(pwdata[15:0]) & rtc_value_pkg::MASK_ALARM_MONTH_DAY))
		else $error("alarm write wrong");

	// weekday/hours stays put unless an unlocked write reaches it
	AST_WKHR_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		!wrWkHr
		|=> $stable(weekdayHours))
		else $error("weekday value changed without a write");

	// minutes/seconds stays put unless a write reaches it
	AST_MINUTES_SECONDS_VALUE_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
		!wrMinSec
		|=> $stable(minutesSeconds))
		else $error("minutes value changed without a write");

	// alarm month/day stays put unless an unlocked write reaches it
	AST_ALMD_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		!wrAlMd
		|=> $stable(alarmMonthDay))
		else $error("alarm value changed without a write");

	// weekday/hours read returns zero in every unimplemented position
	AST_WKHR_READ: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
		clkEn && psel && !penable && paddr == rtc_value_pkg::ADDR_WEEKDAY_HOURS
		|=> prdata[31:11] == 21'h000000 && prdata[7:6] == 2'h0)
		else $error("weekday reserved bits read nonzero");

	// minutes/seconds read returns zero in bit 15, bit 7 and the upper half
	AST_MINUTES_SECONDS_VALUE_READ: assert property (@(posedge sys_clk) disable iff (rst) // [R5] [R8]
		clkEn && psel && !penable && paddr == rtc_value_pkg::ADDR_MINUTES_SECONDS
		|=> prdata[31:15] == 17'h00000 && prdata[7] == 1'b0)
		else $error("minutes reserved bits read nonzero");

	// alarm month/day read returns zero in every unimplemented position
	AST_ALMD_READ: assert property (@(posedge sys_clk) disable iff (rst) // [R10] [R5]
		clkEn && psel && !penable && paddr == rtc_value_pkg::ADDR_ALARM_MONTH_DAY
		|=> prdata[31:13] == 19'h00000 && prdata[7:6] == 2'h0)
		else $error("alarm reserved bits read nonzero");

	// an unmapped read answers with zero data
	AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
		clkEn && psel && !penable && !isMapped(paddr)
		|=> prdata == 32'h0000_0000)
		else $error("unmapped read nonzero");

	// the unlock control word shows only its one bit
	AST_UNLOCK_READ: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		clkEn && psel && !penable && paddr == rtc_value_pkg::ADDR_UNLOCK_CTRL
		|=> prdata[31:1] == 31'h0000_0000)
		else $error("unlock control reads extra bits");

	// a write to the unlock control takes the written bit
	AST_UNLOCK_WRITE: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		access && pwrite && paddr == rtc_value_pkg::ADDR_UNLOCK_CTRL
		|=> unlock_q == $past(pwdata[rtc_value_pkg::UNLOCK_BIT]))
		else $error("unlock write wrong");

	// read data stands from its setup cycle until the next setup cycle
	AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(clkEn && psel && !penable)
		|=> $stable(prdata))
		else $error("read data changed outside a setup cycle");

	// clock enable low freezes the unlock bit
	AST_FREEZE_UNLOCK: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		!clkEn
		|=> $stable(unlock_q))
		else $error("unlock changed while frozen");

	// clock enable low freezes the unguarded register too
	AST_FREEZE_MINUTES_SECONDS_VALUE: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
		!clkEn
		|=> $stable(minutesSeconds))
		else $error("minutes changed while frozen");

	// a mapped address never answers with an error
	AST_MAPPED_NO_ERR: assert property (@(posedge sys_clk) disable iff (rst)
		psel && penable && isMapped(paddr)
		|-> !pslverr)
		else $error("mapped access flagged as error");

	// main scenarios that the bench is expected to reach
	COV_UNLOCKED_WRITE: cover property (@(posedge sys_clk) wrWkHr);
	COV_LOCKED_WRITE: cover property (@(posedge sys_clk)
		access && pwrite && paddr == rtc_value_pkg::ADDR_ALARM_MONTH_DAY && !unlock_q);
	COV_MINUTES_SECONDS_VALUE_WRITE: cover property (@(posedge sys_clk) wrMinSec);
	COV_FROZEN_WRITE: cover property (@(posedge sys_clk)
		psel && penable && pwrite && !clkEn);
	COV_UNMAPPED: cover property (@(posedge sys_clk) pslverr);
endmodule // rtc_time_alarm_value_regs

/* rtc_time_alarm_value_regs_tb.sv */
module rtc_time_alarm_value_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// design ports; clkEn stays at run for the whole test except in testFreeze
	logic sys_clk, rst, clkEn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	int fails = 0;
	int checks = 0;
	int cycles = 0;
	rtc_time_alarm_value_regs DUT (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	// free-running 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			summarize();
		end
	end
	task automatic summarize();
		if (fails == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; held until pready is seen high, data taken at that edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// all ones written while unlocked; only the documented fields come back
	task automatic testMasks();
		logic [7:0] adr [3];
		logic [31:0] msk [3];
		adr = '{8'h00, 8'h04, 8'h08};
		msk = '{32'h0000073f, 32'h00007f7f, 32'h00001f3f};
		apb(1'b1, rtc_value_pkg::ADDR_UNLOCK_CTRL, 32'h00000001);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, adr[i], 32'hffffffff);
			apb(1'b0, adr[i], 32'h00000000);
			chk("masked value", msk[i], rd);
		end
	endtask
	// writes to protected registers are dropped once the unlock bit is cleared
	task automatic testLock();
		apb(1'b1, 8'h00, 32'h00000623);
		apb(1'b1, 8'h08, 32'h00001231);
		apb(1'b1, rtc_value_pkg::ADDR_UNLOCK_CTRL, 32'h00000000);
		apb(1'b1, 8'h00, 32'h00000000);
		apb(1'b1, 8'h08, 32'h00000000);
		apb(1'b1, 8'h04, 32'h00005959);
		apb(1'b0, 8'h00, 32'h00000000);
		chk("weekday_hours_value", 32'h00000623, rd);
		apb(1'b0, 8'h08, 32'h00000000);
		chk("alarm_month_day_value", 32'h00001231, rd);
		apb(1'b0, 8'h04, 32'h00000000);
		chk("minutes_seconds_value", 32'h00005959, rd);
	endtask
	// unmapped place: error response, zero data, no side effect
	task automatic testUnmapped();
		apb(1'b0, 8'h10, 32'h00000000);
		chk("unmapped read data", 32'h00000000, rd);
		chk("unmapped read error", 32'h00000001, {31'h0, err});
		apb(1'b1, 8'h14, 32'h00000000);
		chk("unmapped write error", 32'h00000001, {31'h0, err});
		apb(1'b0, 8'h04, 32'h00000000);
		chk("minutes_seconds_value", 32'h00005959, rd);
	endtask
	// clock enable low: a write in that window must be lost
	task automatic testFreeze();
		@(posedge sys_clk);
		clkEn <= 1'b0;
		apb(1'b1, 8'h04, 32'h00000000);
		@(posedge sys_clk);
		clkEn <= 1'b1;
		apb(1'b0, 8'h04, 32'h00000000);
		chk("frozen minutes_seconds_value", 32'h00005959, rd);
	endtask
	// reset in mid-run closes the unlock bit again
	task automatic testReset();
		apb(1'b1, rtc_value_pkg::ADDR_UNLOCK_CTRL, 32'h00000001);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		apb(1'b0, rtc_value_pkg::ADDR_UNLOCK_CTRL, 32'h00000000);
		chk("clock_write_unlock", 32'h00000000, rd);
		apb(1'b1, 8'h00, 32'h00000000);
		apb(1'b0, 8'h00, 32'h00000000);
		chk("weekday_hours_value", 32'h00000623, rd);
	endtask
	initial begin
		rst = 1'b1;
		clkEn = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		testMasks();
		testLock();
		testUnmapped();
		testFreeze();
		testReset();
		summarize();
	end
endmodule // rtc_time_alarm_value_regs_tb
